// ==== pcoc_clkdiv.sv ====
package pcoc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;
    localparam logic [7:0] CTRL_RESET = 8'hE0;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int CLK_ON_BIT = 4;
    localparam int DIV_HI = 3;
    localparam int DIV_LO = 2;
    localparam int SER_ON_BIT = 1;
    localparam logic [1:0] DIV_SYS = 2'h0;
    localparam logic [1:0] DIV_4 = 2'h1;
    localparam logic [1:0] DIV_8 = 2'h2;
    localparam logic [1:0] DIV_TMR = 2'h3;
    localparam logic [2:0] MODE_SPI_M4 = 3'h0;
    localparam logic [2:0] MODE_SPI_M16 = 3'h1;
    localparam logic [2:0] MODE_SPI_M64 = 3'h2;
    localparam logic [2:0] MODE_SPI_MSUB = 3'h3;
    localparam logic [2:0] MODE_SPI_MTMR = 3'h4;
    localparam logic [2:0] MODE_SPI_SLV = 3'h5;
    localparam logic [2:0] MODE_I2C_SLV = 3'h6;
    localparam int CNT_W = 7;
    localparam int TAP_SYS = 0;
    localparam int TAP_SYS4 = 2;
    localparam int TAP_SYS8 = 3;
    localparam int TAP_SYS16 = 4;
    localparam int TAP_SYS64 = 6;
endpackage : pcoc_pkg

`timescale 1ns/1ps
`default_nettype none

module pcoc_clkdiv #(
    parameter int WIDTH = pcoc_pkg::CNT_W
) (
    input wire logic mclk,
    input wire logic reset_n,
    output logic [WIDTH-1:0] taps
);
    import pcoc_pkg::*;

    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;

    // The counter never stops, so every tap stays phase locked to the others.
    always_comb
    begin
        cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    assign taps = cnt_reg;
endmodule : pcoc_clkdiv

`default_nettype wire

// ==== pcoc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcoc_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [pcoc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pcoc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [pcoc_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sleep_mode,
    input wire logic serial_option_en,
    input wire logic timer0_half_rate_clk,
    input wire logic sub_clock,
    input wire logic port_out_data,
    input wire logic port_out_en,
    output logic shared_port_pin_o,
    output logic shared_port_pin_oe,
    output logic serial_iface_active,
    output logic spi_master_en,
    output logic spi_slave_en,
    output logic i2c_slave_en,
    output logic spi_master_clk,
    output logic spi_ctrl_init
);
    import pcoc_pkg::*;

    logic [CNT_W-1:0] taps;
    logic [7:1] ctrl_reg, ctrl_next;
    logic wait_reg, wait_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic sub_meta_reg, sub_sync_reg;
    logic pin_o_reg, pin_o_next, pin_oe_reg, pin_oe_next;
    logic ser_reg, ser_next, init_reg, init_next;
    logic mst_reg, mst_next, slv_reg, slv_next, i2c_reg, i2c_next;
    logic sclk_reg, sclk_next;
    logic req, wr_take, clk_src;
    logic [1:0] div_sel;
    logic [2:0] mode;

    pcoc_clkdiv #(
        .WIDTH(CNT_W)
    ) u_div (
        .mclk(mclk),
        .reset_n(reset_n),
        .taps(taps)
    );

    assign req = avs_read | avs_write;
    assign wr_take = avs_write & ~wait_reg & avs_byteenable[0] & (avs_address == CTRL_ADDR);
    assign div_sel = ctrl_reg[DIV_HI:DIV_LO];
    assign mode = ctrl_reg[MODE_HI:MODE_LO];

    // Every access costs one wait cycle; read data is captured while waitrequest is high.
    always_comb
    begin
        wait_next = ~(req & wait_reg);
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        if (req & wait_reg)
        begin
            rdata_next = '0;
            if (avs_address == CTRL_ADDR)
                rdata_next[7:0] = {ctrl_reg, 1'b0};
            else if (avs_address == STAT_ADDR)
                rdata_next[4:0] = {sub_sync_reg, serial_option_en, sleep_mode, ser_reg, pin_oe_reg};
        end
        if (wr_take)
            ctrl_next = avs_writedata[7:1];
    end

    always_comb
    begin
        case (div_sel)
            DIV_SYS: clk_src = taps[TAP_SYS];
            DIV_4: clk_src = taps[TAP_SYS4];
            DIV_8: clk_src = taps[TAP_SYS8];
            default: clk_src = timer0_half_rate_clk;
        endcase
        if (ctrl_reg[CLK_ON_BIT] & ~sleep_mode)
        begin
            pin_o_next = clk_src;
            pin_oe_next = 1'b1;
        end
        else
        begin
            pin_o_next = port_out_data;
            pin_oe_next = port_out_en;
        end
    end

    always_comb
    begin
        ser_next = ctrl_reg[SER_ON_BIT] & serial_option_en;
        init_next = ser_next & ~ser_reg;
        mst_next = ser_next & (mode <= MODE_SPI_MTMR);
        slv_next = ser_next & (mode == MODE_SPI_SLV);
        i2c_next = ser_next & (mode == MODE_I2C_SLV);
        case (mode)
            MODE_SPI_M4: sclk_next = taps[TAP_SYS4];
            MODE_SPI_M16: sclk_next = taps[TAP_SYS16];
            MODE_SPI_M64: sclk_next = taps[TAP_SYS64];
            MODE_SPI_MSUB: sclk_next = sub_sync_reg;
            MODE_SPI_MTMR: sclk_next = timer0_half_rate_clk;
            default: sclk_next = 1'b0;
        endcase
        sclk_next = sclk_next & mst_next;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= CTRL_RESET[7:1];
            wait_reg <= 1'b1;
            rdata_reg <= '0;
            sub_meta_reg <= 1'b0;
            sub_sync_reg <= 1'b0;
            pin_o_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            ser_reg <= 1'b0;
            init_reg <= 1'b0;
            mst_reg <= 1'b0;
            slv_reg <= 1'b0;
            i2c_reg <= 1'b0;
            sclk_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            sub_meta_reg <= sub_clock;
            sub_sync_reg <= sub_meta_reg;
            pin_o_reg <= pin_o_next;
            pin_oe_reg <= pin_oe_next;
            ser_reg <= ser_next;
            init_reg <= init_next;
            mst_reg <= mst_next;
            slv_reg <= slv_next;
            i2c_reg <= i2c_next;
            sclk_reg <= sclk_next;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign shared_port_pin_o = pin_o_reg;
    assign shared_port_pin_oe = pin_oe_reg;
    assign serial_iface_active = ser_reg;
    assign spi_master_en = mst_reg;
    assign spi_slave_en = slv_reg;
    assign i2c_slave_en = i2c_reg;
    assign spi_master_clk = sclk_reg;
    assign spi_ctrl_init = init_reg;

    AST_BIT0_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
        (avs_read & wait_reg & (avs_address == CTRL_ADDR)) |=> !avs_readdata[0])
        else $error("Control bit 0 read back nonzero.");

    AST_WRITE_ENABLE: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_take |=> (ctrl_reg[CLK_ON_BIT] == $past(avs_writedata[CLK_ON_BIT])))
        else $error("Clock output enable write not stored.");

    AST_ENABLE_DRIVES: assert property (@(posedge mclk) disable iff (!reset_n)
        (ctrl_reg[CLK_ON_BIT] & !sleep_mode) |=> shared_port_pin_oe)
        else $error("Enabled clock output not driving pin.");

    AST_SLEEP_STOPS: assert property (@(posedge mclk) disable iff (!reset_n)
        sleep_mode |=> (shared_port_pin_oe == $past(port_out_en))
            && (shared_port_pin_o == $past(port_out_data)))
        else $error("Clock output kept running in sleep.");

    AST_DISABLED_PORT: assert property (@(posedge mclk) disable iff (!reset_n)
        !ctrl_reg[CLK_ON_BIT] |=> (shared_port_pin_o == $past(port_out_data)))
        else $error("Disabled clock output did not free the pin.");

    AST_DIV4: assert property (@(posedge mclk) disable iff (!reset_n)
        (ctrl_reg[CLK_ON_BIT] & !sleep_mode & (div_sel == DIV_4))
            |=> (shared_port_pin_o == $past(taps[TAP_SYS4])))
        else $error("Quarter rate clock not on pin.");

    AST_SPI_M64: assert property (@(posedge mclk) disable iff (!reset_n)
        (ser_next & (mode == MODE_SPI_M64)) |=> (spi_master_clk == $past(taps[TAP_SYS64])))
        else $error("SPI master clock not system over 64.");

    AST_SLAVE_DECODE: assert property (@(posedge mclk) disable iff (!reset_n)
        (ser_next & (mode == MODE_SPI_SLV)) |=> spi_slave_en && !spi_master_en && !spi_master_clk)
        else $error("SPI slave mode decoded wrongly.");

    AST_OPTION_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
        !serial_option_en |=> !serial_iface_active && !i2c_slave_en)
        else $error("Serial interface on without configuration option.");

    AST_FLOAT_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
        !ctrl_reg[SER_ON_BIT] |=> !serial_iface_active && !spi_master_en)
        else $error("Serial lines active with enable bit clear.");

    AST_INIT_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(serial_iface_active) |-> spi_ctrl_init ##1 !spi_ctrl_init)
        else $error("Setup pulse missing on serial enable.");
endmodule : pcoc_top

`default_nettype wire

// ==== pcoc_clk_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcoc_clk_sink (
    input wire logic mclk,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic [7:0] period
);
    logic [7:0] cnt;
    logic prev;
    // no serial clock
    // This sink only listens, so it never supplies a serial clock of its own.
    initial
    begin
        cnt = 8'h00;
        prev = 1'b0;
        period = 8'h00;
    end
    always @(posedge mclk)
    begin
        cnt <= cnt + 8'h01;
        prev <= pin_o;
        if (pin_oe && pin_o && !prev)
        begin
            period <= cnt;
            cnt <= 8'h01;
        end
    end
endmodule : pcoc_clk_sink
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcoc_pkg::*;
    logic mclk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic sleep_mode, serial_option_en, tmr, port_out_data, port_out_en, sub, sclk;
    logic pin_o, pin_oe, active, m_en, s_en, i_en, init;
    logic [7:0] period;
    int fail_count, comparisons, tcnt, init_cnt;
    int per[4] = '{2, 8, 16, 10};
    pcoc_top i_pcoc_top (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
        .serial_option_en(serial_option_en), .timer0_half_rate_clk(tmr),
        .sub_clock(sub), .port_out_data(port_out_data), .port_out_en(port_out_en),
        .shared_port_pin_o(pin_o), .shared_port_pin_oe(pin_oe),
        .serial_iface_active(active), .spi_master_en(m_en), .spi_slave_en(s_en),
        .i2c_slave_en(i_en), .spi_master_clk(sclk), .spi_ctrl_init(init));
    pcoc_clk_sink i_pcoc_clk_sink (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe),
        .period(period));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = !mclk;
    end
    // The timer output has a 10 cycle period, unlike any divided tap (2, 8 or 16 cycles), so a wrong tap shows at once.
    always @(posedge mclk)
    begin
        tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
        if (tcnt == 4)
            tmr <= !tmr;
        if (init === 1'b1)
            init_cnt <= init_cnt + 1;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge mclk);
        // Only the watchdog ends a wait that never gets its answer.
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge mclk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(name, q, exp);
    endtask : rdchk
    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask : settle
    task automatic report_and_stop();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #100000;
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        {avs_read, avs_write, sleep_mode, tmr, port_out_data, port_out_en} = 6'h00;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        serial_option_en = 1'b1;
        sub = 1'b1;
        {tcnt, init_cnt, fail_count, comparisons} = 4'h0;
        reset_n = 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        rdchk("ctrl_reset", CTRL_ADDR, 32'h0000_00E0);
        bus(1'b1, CTRL_ADDR, 32'h0000_00FF);
        rdchk("ctrl_bit0", CTRL_ADDR, 32'h0000_00FE);
        avs_byteenable <= 4'h0;
        bus(1'b1, CTRL_ADDR, 32'h0000_0000);
        avs_byteenable <= 4'hF;
        rdchk("ctrl_no_lane", CTRL_ADDR, 32'h0000_00FE);
        rdchk("unmapped", 4'h8, 32'h0000_0000);
        bus(1'b1, CTRL_ADDR, 32'h0000_00E0);
        {port_out_en, port_out_data} <= 2'h3;
        settle();
        chk("port_oe", pin_oe, 1'b1);
        chk("port_o", pin_o, 1'b1);
        port_out_en <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, CTRL_ADDR, 32'h0000_0010 | (i << 2));
            repeat (60) @(posedge mclk);
            chk("period", {24'h0, period}, per[i]);
            chk("clk_oe", pin_oe, 1'b1);
        end
        sleep_mode <= 1'b1;
        settle();
        chk("sleep_oe", pin_oe, 1'b0);
        sleep_mode <= 1'b0;
        for (int m = 0; m < 8; m++)
        begin
            bus(1'b1, CTRL_ADDR, (m << 5) | 2);
            settle();
            chk("active", active, 1'b1);
            chk("spi_master", m_en, m < 5);
            chk("spi_slave", s_en, m == 5);
            chk("i2c_slave", i_en, m == 6);
            if (m == 3 || m > 4)
                chk("spi_clk", sclk, m == 3);
        end
        bus(1'b1, CTRL_ADDR, 32'h0000_0000);
        settle();
        chk("idle", active, 1'b0);
        serial_option_en <= 1'b0;
        bus(1'b1, CTRL_ADDR, 32'h0000_0002);
        settle();
        chk("no_option", active, 1'b0);
        serial_option_en <= 1'b1;
        settle();
        rdchk("status", STAT_ADDR, 32'h0000_001A);
        chk("init_pulses", init_cnt, 3);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
